// >>> hw/pcs_port_config.sv
// Purpose: Port pin configuration: direction, sharing, pull and drive.
// Assumes: Mode inputs come from logic on clk; pins are asynchronous.
// Notes: Reads return data in the cycle after the read strobe.
//        Unmapped and reserved addresses read zero and ignore writes.
//        Pads follow register, claim and mode changes one clock later.
`timescale 1ns/1ps
`default_nettype none
module pcs_port_config (
	input  wire logic                                clk,
	input  wire logic                                sys_rst,
	input  wire logic [pcs_pkg::AW-1:0]              addr,
	input  wire logic [7:0]                          wdata,
	input  wire logic                                wr_stb,
	input  wire logic                                rd_stb,
	output logic      [7:0]                          rdata,
	input  wire logic                                mode_expanded,
	input  wire logic                                mode_peripheral,
	input  wire pcs_pkg::pcs_alt_type [pcs_pkg::NPORT-1:0] periph,
	input  wire logic [pcs_pkg::NPORT-1:0][7:0]      pin_in,
	output pcs_pkg::pcs_pad_type [pcs_pkg::NPORT-1:0] pad,
	output logic      [pcs_pkg::NPORT-1:0][7:0]      pin_level,
	input  wire logic [7:0]                          analog_in_zero_pins,
	input  wire logic [7:0]                          analog_in_one_pins,
	output logic      [7:0]                          analog_zero_level,
	output logic      [7:0]                          analog_one_level,
	input  wire logic [pcs_pkg::NCAN-1:0]            can_tx,
	input  wire logic [pcs_pkg::NCAN-1:0]            can_rx_pin,
	output logic      [pcs_pkg::NCAN-1:0]            can_tx_pin,
	output logic      [pcs_pkg::NCAN-1:0]            can_tx_oe,
	output logic      [pcs_pkg::NCAN-1:0]            can_rx_pull,
	output logic      [pcs_pkg::NCAN-1:0]            can_rx,
	output logic                                     pull_en_port_h,
	output logic                                     pull_en_port_j,
	output logic                                     low_drive_port_h,
	output logic                                     low_drive_port_j
);

	logic [pcs_pkg::NPORT-1:0][7:0] data_r;
	logic [pcs_pkg::NPORT-1:0][7:0] dir_r;
	logic [pcs_pkg::NPORT-1:0][7:0] meta_r;
	logic [pcs_pkg::NPORT-1:0][7:0] sync_r;
	logic [pcs_pkg::NPORT-1:0][7:0] own;
	logic [pcs_pkg::NPORT-1:0]      mapped;
	logic [pcs_pkg::NPORT-1:0]      pull_port;
	logic [pcs_pkg::NPORT-1:0]      low_port;
	logic [7:0]                     pull_r;
	logic [7:0]                     lowdrv_r;
	logic                           lowdrv_done_r;
	logic [7:0]                     pwm_r;
	logic [7:0]                     tmr_r;
	logic [7:0]                     ser_r;
	logic [7:0]                     twp_r;
	logic [7:0]                     an0_meta_r;
	logic [7:0]                     an1_meta_r;
	logic [7:0]                     an0_r;
	logic [7:0]                     an1_r;
	logic [pcs_pkg::NCAN-1:0]       can_meta_r;
	logic [pcs_pkg::NCAN-1:0]       can_sync_r;
	logic [7:0]                     rdata_nxt;
	logic                           ext_mode;

	// Expanded and peripheral modes hand the bus ports to the bus logic.
	// Both modes give up the same registers, so one flag serves all decode.
	assign ext_mode = mode_expanded | mode_peripheral;

	// Per-port mapping, ownership and pull/drive bit selection.
	genvar gp;
	generate
		for (gp = 0; gp < pcs_pkg::NPORT; gp++)
		begin : g_port
			if (gp == pcs_pkg::P_A || gp == pcs_pkg::P_B)
			begin : g_bus
				// In the bus modes the bus logic owns every pin, and the claim enables are not used.
				assign mapped[gp] = ~ext_mode;
				assign own[gp] = {8{ext_mode}};
			end
			else if (gp == pcs_pkg::P_K)
			begin : g_page
				// Page index pins; bits 6:4 do not exist on this port.
				assign mapped[gp] = ~ext_mode;
				assign own[gp] = {8{ext_mode}} & pcs_pkg::PIN_MASK[gp];
			end
			else
			begin : g_gen
				assign mapped[gp] = 1'b1;
				// Claims on bits the port lacks are dropped.
				assign own[gp] = periph[gp].en & pcs_pkg::PIN_MASK[gp];
			end
		end
	endgenerate

	// Pull and drive sources differ by port; only the shared bits feed A, B, E, K.
	assign pull_port[pcs_pkg::P_A]  = pull_r[pcs_pkg::B_A];
	assign pull_port[pcs_pkg::P_B]  = pull_r[pcs_pkg::B_B];
	assign pull_port[pcs_pkg::P_E]  = pull_r[pcs_pkg::B_E];
	assign pull_port[pcs_pkg::P_K]  = pull_r[pcs_pkg::B_K];
	// The other ports keep their bits in their own peripheral control registers.
	assign pull_port[pcs_pkg::P_P]  = pwm_r[pcs_pkg::PWM_PULL];
	assign pull_port[pcs_pkg::P_T]  = tmr_r[pcs_pkg::TMR_PULL];
	assign pull_port[pcs_pkg::P_S]  = ser_r[pcs_pkg::SER_PULL];
	assign pull_port[pcs_pkg::P_IB] = twp_r[pcs_pkg::TWP_PULL];

	// Drive reduce follows the same split; analog and CAN pins have none.
	assign low_port[pcs_pkg::P_A]   = lowdrv_r[pcs_pkg::B_A];
	assign low_port[pcs_pkg::P_B]   = lowdrv_r[pcs_pkg::B_B];
	assign low_port[pcs_pkg::P_E]   = lowdrv_r[pcs_pkg::B_E];
	assign low_port[pcs_pkg::P_K]   = lowdrv_r[pcs_pkg::B_K];
	assign low_port[pcs_pkg::P_P]   = pwm_r[pcs_pkg::PWM_LOW];
	assign low_port[pcs_pkg::P_T]   = tmr_r[pcs_pkg::TMR_LOW];
	assign low_port[pcs_pkg::P_S]   = ser_r[pcs_pkg::SER_LOW];
	assign low_port[pcs_pkg::P_IB]  = twp_r[pcs_pkg::TWP_LOW];

	// Port pins pass two flops before anything reads them; only the second is looked at.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	// Analog pins are read as plain digital levels through the same two stages.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			an0_meta_r <= 8'h00;
			an1_meta_r <= 8'h00;
			an0_r      <= 8'h00;
			an1_r      <= 8'h00;
		end
		else
		begin
			an0_meta_r <= analog_in_zero_pins;
			an1_meta_r <= analog_in_one_pins;
			an0_r      <= an0_meta_r;
			an1_r      <= an1_meta_r;
		end
	end

	// CAN receive stages reset recessive, so no false frame start follows reset.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			can_meta_r <= '1;
			can_sync_r <= '1;
		end
		else
		begin
			can_meta_r <= can_rx_pin;
			can_sync_r <= can_meta_r;
		end
	end

	// Port data latches; writes to an unmapped latch are dropped.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			data_r <= '0;
		else if (wr_stb)
		begin
			for (int i = 0; i < pcs_pkg::NPORT; i++)
			begin
				if (addr == pcs_pkg::DATA_OFS[i] && mapped[i])
					data_r[i] <= wdata & pcs_pkg::PIN_MASK[i];
			end
		end
	end

	// Direction latches reset to input; fixed-input bits never store.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			dir_r <= '0;
		else if (wr_stb)
		begin
			for (int i = 0; i < pcs_pkg::NPORT; i++)
			begin
				if (addr == pcs_pkg::DIR_OFS[i] && mapped[i])
					dir_r[i] <= wdata & pcs_pkg::OUT_MASK[i];
			end
		end
	end

	// Shared pull enables; the unused bits 3:2 read back as zero.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pull_r <= pcs_pkg::PULL_RST;
		else if (wr_stb && addr == pcs_pkg::OFS_PULL)
			pull_r <= wdata & pcs_pkg::PULL_MAP_MASK;
	end

	// Modulator control, which also carries the port P pull and drive bits.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pwm_r <= pcs_pkg::PWM_RST;
		else if (wr_stb && addr == pcs_pkg::OFS_PWM)
			pwm_r <= wdata;
	end

	// Timer control, which also carries the port T pull and drive bits.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tmr_r <= pcs_pkg::TMR_RST;
		else if (wr_stb && addr == pcs_pkg::OFS_TMR)
			tmr_r <= wdata;
	end

	// Serial control resets with the port S pull already on.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ser_r <= pcs_pkg::SER_RST;
		else if (wr_stb && addr == pcs_pkg::OFS_SER)
			ser_r <= wdata;
	end

	// Two-wire port pull and drive control.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			twp_r <= pcs_pkg::TWP_RST;
		else if (wr_stb && addr == pcs_pkg::OFS_TWP)
			twp_r <= wdata;
	end

	// Shared drive reduce takes one write after reset, so a runaway program
	// cannot later weaken the port A, B, E, K, H and J outputs it controls.
	// The done flag is not visible to software; only reset clears it.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lowdrv_r      <= pcs_pkg::LOWDRV_RST;
			lowdrv_done_r <= 1'b0;
		end
		else if (wr_stb && addr == pcs_pkg::OFS_LOWDRV && !lowdrv_done_r)
		begin
			lowdrv_r      <= wdata & pcs_pkg::PULL_MAP_MASK;
			lowdrv_done_r <= 1'b1;
		end
	end

	// Read multiplexer; unmapped and reserved addresses read zero.
	// Data reads show the latch on outputs and the synchronised pin on inputs.
	always_comb
	begin
		rdata_nxt = 8'h00;
		for (int i = 0; i < pcs_pkg::NPORT; i++)
		begin
			if (addr == pcs_pkg::DATA_OFS[i] && mapped[i])
				rdata_nxt = ((data_r[i] & dir_r[i]) | (sync_r[i] & ~dir_r[i]))
					& pcs_pkg::PIN_MASK[i];
			if (addr == pcs_pkg::DIR_OFS[i] && mapped[i])
				rdata_nxt = dir_r[i];
		end
		// Control registers sit at fixed addresses outside the port table.
		unique case (addr)
			pcs_pkg::OFS_PULL:   rdata_nxt = pull_r;
			pcs_pkg::OFS_LOWDRV: rdata_nxt = lowdrv_r;
			pcs_pkg::OFS_PWM:    rdata_nxt = pwm_r;
			pcs_pkg::OFS_TMR:    rdata_nxt = tmr_r;
			pcs_pkg::OFS_SER:    rdata_nxt = ser_r;
			pcs_pkg::OFS_TWP:    rdata_nxt = twp_r;
			pcs_pkg::OFS_AN0:    rdata_nxt = an0_r;
			pcs_pkg::OFS_AN1:    rdata_nxt = an1_r;
			default: ;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	// Returning zero otherwise keeps a stale value from looking like an answer.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata <= 8'h00;
		else if (rd_stb)
			rdata <= rdata_nxt;
		else
			rdata <= 8'h00;
	end

	// Pad drive: a claiming peripheral replaces data and direction.
	// Pulls act only on pins that are not driven.
	// Input-only pins are never driven, whatever software or a claim asks.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pad <= '0;
		else
		begin
			for (int i = 0; i < pcs_pkg::NPORT; i++)
			begin
				for (int b = 0; b < 8; b++)
				begin
					pad[i].out[b] <= own[i][b] ? periph[i].out[b]
						: data_r[i][b];
					pad[i].oe[b] <= (own[i][b] ? periph[i].oe[b]
						: dir_r[i][b]) & pcs_pkg::OUT_MASK[i][b];
					pad[i].pull[b] <= pull_port[i] & pcs_pkg::PULL_MASK[i][b]
						& ~(own[i][b] ? periph[i].oe[b] : dir_r[i][b]);
					pad[i].low[b] <= low_port[i] & pcs_pkg::LOW_MASK[i][b];
				end
			end
		end
	end

	// Synchronised pin levels for peripherals and analog readback.
	// This adds one clock of latency on top of the two synchroniser stages.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_level         <= '0;
			analog_zero_level <= 8'h00;
			analog_one_level  <= 8'h00;
		end
		else
		begin
			pin_level         <= sync_r;
			analog_zero_level <= an0_r;
			analog_one_level  <= an1_r;
		end
	end

	// CAN pins belong to their controllers with no software control.
	// Reset leaves the transmit pin recessive and the receive pull-up on.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			can_tx_pin  <= '1;
			can_tx_oe   <= '1;
			can_rx_pull <= '1;
			can_rx      <= '1;
		end
		else
		begin
			can_tx_pin  <= can_tx;
			can_tx_oe   <= '1;
			can_rx_pull <= '1;
			can_rx      <= can_sync_r;
		end
	end

	// Ports H and J only receive their pull and drive bits here.
	// Their pull direction and the pins themselves are handled elsewhere.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pull_en_port_h   <= 1'b0;
			pull_en_port_j   <= 1'b0;
			low_drive_port_h <= 1'b0;
			low_drive_port_j <= 1'b0;
		end
		else
		begin
			pull_en_port_h   <= pull_r[pcs_pkg::B_H];
			pull_en_port_j   <= pull_r[pcs_pkg::B_J];
			low_drive_port_h <= lowdrv_r[pcs_pkg::B_H];
			low_drive_port_j <= lowdrv_r[pcs_pkg::B_J];
		end
	end

endmodule : pcs_port_config
`default_nettype wire

// >>> hw/pcs_pkg.sv
// Purpose: Constants and types for the port pin configuration block.
// Assumes: 8-bit registers in a 1K byte register block, 100 MHz clock.
// Notes: Port index order is A, B, E, K, P, T, S, two-wire port.
package pcs_pkg;

	localparam int NPORT = 8;
	localparam int P_A   = 0;
	localparam int P_B   = 1;
	localparam int P_E   = 2;
	localparam int P_K   = 3;
	localparam int P_P   = 4;
	localparam int P_T   = 5;
	localparam int P_S   = 6;
	localparam int P_IB  = 7;
	localparam int NCAN  = 3;
	localparam int AW    = 10;

	// Data and direction offsets per port.
	localparam logic [AW-1:0] DATA_OFS [NPORT] = '{10'h000, 10'h001, 10'h008, 10'h0FC,
		10'h056, 10'h0AE, 10'h0D6, 10'h0E6};
	localparam logic [AW-1:0] DIR_OFS [NPORT] = '{10'h002, 10'h003, 10'h009, 10'h0FD,
		10'h057, 10'h0AF, 10'h0D7, 10'h0E7};
	// Implemented pins and output-capable pins per port.
	localparam logic [7:0] PIN_MASK [NPORT] = '{8'hFF, 8'hFF, 8'hFF, 8'h8F,
		8'h0F, 8'hFF, 8'hFF, 8'hC0};
	localparam logic [7:0] OUT_MASK [NPORT] = '{8'hFF, 8'hFF, 8'hFC, 8'h8F,
		8'h0F, 8'hFF, 8'hFF, 8'hC0};
	// Pins with a pull device and pins with drive control.
	localparam logic [7:0] PULL_MASK [NPORT] = '{8'hFF, 8'hFF, 8'h8F, 8'h8F,
		8'h0F, 8'hFF, 8'hFF, 8'hC0};
	localparam logic [7:0] LOW_MASK [NPORT] = '{8'hFF, 8'hFF, 8'hFC, 8'h8F,
		8'h0F, 8'hFF, 8'hFF, 8'hC0};

	localparam logic [AW-1:0] OFS_PULL   = 10'h00C;
	localparam logic [AW-1:0] OFS_LOWDRV = 10'h00D;
	localparam logic [AW-1:0] OFS_PWM    = 10'h054;
	localparam logic [AW-1:0] OFS_TMR    = 10'h08D;
	localparam logic [AW-1:0] OFS_SER    = 10'h0D1;
	localparam logic [AW-1:0] OFS_TWP    = 10'h0E5;
	localparam logic [AW-1:0] OFS_AN0    = 10'h06F;
	localparam logic [AW-1:0] OFS_AN1    = 10'h07F;

	// Shared pull enable and drive reduce bit positions.
	localparam int B_A = 0;
	localparam int B_B = 1;
	localparam int B_E = 4;
	localparam int B_H = 5;
	localparam int B_J = 6;
	localparam int B_K = 7;
	localparam logic [7:0] PULL_MAP_MASK = 8'hF3;
	// Pull and drive bits inside the peripheral control registers.
	localparam int PWM_PULL = 3;
	localparam int PWM_LOW  = 2;
	localparam int TMR_PULL = 5;
	localparam int TMR_LOW  = 4;
	localparam int SER_PULL = 3;
	localparam int SER_LOW  = 4;
	localparam int TWP_PULL = 0;
	localparam int TWP_LOW  = 1;

	localparam logic [7:0] PULL_RST = 8'h10;
	localparam logic [7:0] LOWDRV_RST = 8'h00;
	localparam logic [7:0] PWM_RST = 8'h00;
	localparam logic [7:0] TMR_RST = 8'h00;
	localparam logic [7:0] SER_RST = 8'h08;
	localparam logic [7:0] TWP_RST = 8'h00;

	// A peripheral's claim on a port: enable, drive value, drive enable.
	typedef struct packed {
		logic [7:0] en;
		logic [7:0] out;
		logic [7:0] oe;
	} pcs_alt_type;

	// What reaches one port's pads.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull;
		logic [7:0] low;
	} pcs_pad_type;

endpackage : pcs_pkg

// >>> verification/pcs_port_chk.sv
// Purpose: Concurrent checks on the ports of the port configuration block.
// Assumes: Pads follow their controls one clock later; reads answer one clock later.
// Notes: Bound to every instance of the block; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pcs_port_chk (
	input wire logic                                  clk,
	input wire logic                                  sys_rst,
	input wire logic [pcs_pkg::AW-1:0]                addr,
	input wire logic [7:0]                            wdata,
	input wire logic                                  wr_stb,
	input wire logic                                  rd_stb,
	input wire logic [7:0]                            rdata,
	input wire logic                                  mode_expanded,
	input wire logic                                  mode_peripheral,
	input wire pcs_pkg::pcs_alt_type [pcs_pkg::NPORT-1:0] periph,
	input wire pcs_pkg::pcs_pad_type [pcs_pkg::NPORT-1:0] pad,
	input wire logic [pcs_pkg::NCAN-1:0]              can_tx,
	input wire logic [pcs_pkg::NCAN-1:0]              can_tx_pin,
	input wire logic [pcs_pkg::NCAN-1:0]              can_tx_oe,
	input wire logic [pcs_pkg::NCAN-1:0]              can_rx_pull,
	input wire logic [pcs_pkg::NCAN-1:0]              can_rx_pin,
	input wire logic [pcs_pkg::NCAN-1:0]              can_rx
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// A direction write to port T, then a quiet cycle with the timer idle.
	sequence s_dir_t;
		(wr_stb && addr == 10'h0AF) ##1 (periph[5].en == 8'h00 && !wr_stb);
	endsequence
	// The modulator holds port P bits 3:0 for two cycles.
	sequence s_pwm_held;
		periph[4].en[3:0] == 4'hF [*2];
	endsequence

	property p_can_fixed;
		can_tx_oe == 3'h7 && can_rx_pull == 3'h7;
	endproperty
	a_can_fixed: assert property (p_can_fixed) else $error("CAN pin controls moved");
	// The first edge after reset still sees the reset value, so it is skipped.
	property p_can_tx;
		!$past(sys_rst) |-> can_tx_pin == $past(can_tx);
	endproperty
	a_can_tx: assert property (p_can_tx) else $error("CAN transmit pin lags wrongly");
	// Two synchroniser stages and an output flop; reset-time stages are skipped.
	property p_can_rx;
		!$past(sys_rst, 3) |-> can_rx == $past(can_rx_pin, 3);
	endproperty
	a_can_rx: assert property (p_can_rx) else $error("CAN receive line lags wrongly");
	property p_e_in_only;
		pad[2].oe[1:0] == 2'h0;
	endproperty
	a_e_in_only: assert property (p_e_in_only) else $error("Port E input pin driven");
	property p_e_nopull;
		pad[2].pull[6:4] == 3'h0;
	endproperty
	a_e_nopull: assert property (p_e_nopull) else $error("Port E pin without pull pulled");
	property p_s_pull_gap;
		(pad[6].pull & pad[6].oe) == 8'h00;
	endproperty
	a_s_pull_gap: assert property (p_s_pull_gap) else $error("Port S pull on output");
	property p_rd_stands;
		rdata != 8'h00 |-> $past(rd_stb);
	endproperty
	a_rd_stands: assert property (p_rd_stands) else $error("Read data outside its cycle");
	property p_dir_t;
		s_dir_t |=> pad[5].oe == $past(wdata, 2);
	endproperty
	a_dir_t: assert property (p_dir_t) else $error("Port T direction not on pads");
	property p_pwm_claim;
		s_pwm_held |-> pad[4].oe[3:0] == $past(periph[4].oe[3:0]);
	endproperty
	a_pwm_claim: assert property (p_pwm_claim) else $error("Modulator lost port P");
	property p_ab_bus;
		mode_expanded [*2] |-> pad[0].oe == $past(periph[0].oe) && pad[1].oe == $past(periph[1].oe);
	endproperty
	a_ab_bus: assert property (p_ab_bus) else $error("Ports A and B not on the bus");
	property p_ab_gone;
		rd_stb && addr <= 10'h003 && (mode_expanded || mode_peripheral) |=> rdata == 8'h00;
	endproperty
	a_ab_gone: assert property (p_ab_gone) else $error("Ports A and B still mapped");
endmodule : pcs_port_chk

bind pcs_port_config pcs_port_chk u_chk (.clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb,
	.rdata, .mode_expanded, .mode_peripheral, .periph, .pad, .can_tx, .can_tx_pin,
	.can_tx_oe, .can_rx_pull, .can_rx_pin, .can_rx);
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Self-checking bench for the port configuration block.
// Assumes: Reads answer in the cycle after the strobe; pads lag registers by one clock.
// Notes: Pin and CAN inputs are random from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", nm, e, a); end end
module tb;
	logic                                      clk = 1'b0;
	logic                                      sys_rst = 1'b1;
	logic                                      wr_stb = 1'b0;
	logic                                      rd_stb = 1'b0;
	logic                                      mode_expanded = 1'b0;
	logic                                      mode_peripheral = 1'b0;
	logic [9:0]                                addr = 10'h000;
	logic [7:0]                                wdata = 8'h00;
	logic [7:0]                                rdata;
	logic [7:0]                                analog_in_zero_pins = 8'h00;
	logic [7:0]                                analog_in_one_pins = 8'h00;
	logic [7:0]                                analog_zero_level;
	logic [7:0]                                analog_one_level;
	pcs_pkg::pcs_alt_type [pcs_pkg::NPORT-1:0] periph = '0;
	pcs_pkg::pcs_pad_type [pcs_pkg::NPORT-1:0] pad;
	logic [pcs_pkg::NPORT-1:0][7:0]            pin_in = '0;
	logic [pcs_pkg::NPORT-1:0][7:0]            pin_level;
	logic [2:0]                                can_tx = 3'h7;
	logic [2:0]                                can_rx_pin = 3'h7;
	logic [2:0]                                can_tx_pin;
	logic [2:0]                                can_tx_oe;
	logic [2:0]                                can_rx_pull;
	logic [2:0]                                can_rx;
	logic                                      pull_en_port_h;
	logic                                      pull_en_port_j;
	logic                                      low_drive_port_h;
	logic                                      low_drive_port_j;
	logic [7:0]                                exp_q [$];
	logic [7:0]                                e_r;
	logic                                      rd_seen = 1'b0;
	int                                        miscompares = 0;
	int                                        samples_checked = 0;
	int                                        seed = 79;
	int                                        cyc = 0;

	pcs_port_config dut (.clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.mode_expanded, .mode_peripheral, .periph, .pin_in, .pad, .pin_level,
		.analog_in_zero_pins, .analog_in_one_pins, .analog_zero_level, .analog_one_level,
		.can_tx, .can_rx_pin, .can_tx_pin, .can_tx_oe, .can_rx_pull, .can_rx,
		.pull_en_port_h, .pull_en_port_j, .low_drive_port_h, .low_drive_port_j);

	always #5 clk = ~clk;

	// Read data are scored half a cycle after the answering edge, once they have settled.
	always @(posedge clk) rd_seen <= rd_stb;
	always @(negedge clk)
	begin
		if (rd_seen)
		begin
			e_r = exp_q.pop_front();
			`CHK("rdata", e_r, rdata)
		end
	end

	// CAN lines change every cycle; the checker ties the pin copies to them.
	always @(posedge clk)
	begin
		can_tx     <= 3'($random(seed));
		can_rx_pin <= 3'($random(seed));
	end

	// A hang ends the run as a failure.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			miscompares++;
			finish_test();
		end
	end

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr

	// The expected value is noted when the read is issued.
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge clk);
		addr   <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	// Main sequence.
	initial
	begin
		logic [7:0] v [8];
		logic [7:0] x;
		logic [7:0] y;
		pin_in <= {$random(seed), $random(seed)};
		analog_in_zero_pins <= 8'($random(seed));
		analog_in_one_pins <= 8'($random(seed));
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		idle(1);
		for (int p = 0; p < pcs_pkg::NPORT; p++)
		begin
			rd(pcs_pkg::DIR_OFS[p], 8'h00);
			`CHK("pad.low", 8'h00, pad[p].low)
		end
		rd(pcs_pkg::OFS_PULL, 8'h10);
		rd(pcs_pkg::OFS_LOWDRV, 8'h00);
		rd(pcs_pkg::OFS_SER, 8'h08);
		rd(pcs_pkg::OFS_PWM, 8'h00);
		rd(pcs_pkg::OFS_TMR, 8'h00);
		rd(pcs_pkg::OFS_TWP, 8'h00);
		rd(10'h3FF, 8'h00);
		`CHK("pin_level", pin_in, pin_level)
		`CHK("analog_zero_level", analog_in_zero_pins, analog_zero_level)
		`CHK("analog_one_level", analog_in_one_pins, analog_one_level)
		`CHK("pull_en_port_h", 1'b0, pull_en_port_h)
		`CHK("low_drive_port_j", 1'b0, low_drive_port_j)
		$display("test reset done");
		// Direction bits drive the pads, and pulls let go of outputs.
		for (int p = 0; p < pcs_pkg::NPORT; p++)
		begin
			v[p] = 8'($random(seed));
			wr(pcs_pkg::DIR_OFS[p], v[p]);
			idle(2);
			x = v[p] & pcs_pkg::OUT_MASK[p];
			y = (p == pcs_pkg::P_E || p == pcs_pkg::P_S) ? pcs_pkg::PULL_MASK[p] & ~x : 8'h00;
			`CHK("pad.oe", x, pad[p].oe)
			`CHK("pad.pull", y, pad[p].pull)
			rd(pcs_pkg::DIR_OFS[p], x);
		end
		wr(pcs_pkg::DATA_OFS[0], 8'h5A);
		idle(2);
		`CHK("pad.out", 8'h5A, pad[0].out)
		rd(pcs_pkg::DATA_OFS[0], (8'h5A & v[0]) | (pin_in[0] & ~v[0]));
		$display("test direction done");
		// Both bus modes hand ports A, B and K to the bus and hide their registers.
		for (int m = 0; m < 2; m++)
		begin
			@(posedge clk);
			mode_expanded   <= (m == 0);
			mode_peripheral <= (m == 1);
			for (int q = 0; q < pcs_pkg::NPORT; q++)
				periph[q] <= 24'($random(seed));
			idle(2);
			for (int q = 0; q < 4; q++)
				if (q != pcs_pkg::P_E)
				begin
					y = pcs_pkg::OUT_MASK[q];
					`CHK("pad.oe", periph[q].oe & y, pad[q].oe & y)
					`CHK("pad.out", periph[q].out & y, pad[q].out & y)
				end
			wr(pcs_pkg::DIR_OFS[0], ~v[0]);
			rd(pcs_pkg::DIR_OFS[0], 8'h00);
			rd(pcs_pkg::DATA_OFS[1], 8'h00);
			rd(pcs_pkg::DIR_OFS[pcs_pkg::P_K], 8'h00);
		end
		@(posedge clk);
		mode_expanded   <= 1'b0;
		mode_peripheral <= 1'b0;
		// Low nibble always claimed so the modulator case is surely reached.
		for (int q = 2; q < pcs_pkg::NPORT; q++)
			periph[q] <= {8'($random(seed)) | 8'h0F, 16'($random(seed))};
		idle(3);
		rd(pcs_pkg::DIR_OFS[0], v[0]);
		for (int q = 2; q < pcs_pkg::NPORT; q++)
			if (q != pcs_pkg::P_K)
			begin
				y = ((periph[q].en & periph[q].oe) | (~periph[q].en & v[q])) & pcs_pkg::OUT_MASK[q];
				`CHK("pad.oe", y, pad[q].oe & pcs_pkg::OUT_MASK[q])
			end
		@(posedge clk);
		periph <= '0;
		$display("test sharing done");
		// Only the first drive write after reset sticks.
		wr(pcs_pkg::OFS_LOWDRV, 8'hFF);
		wr(pcs_pkg::OFS_LOWDRV, 8'h00);
		wr(pcs_pkg::OFS_PULL, 8'h60);
		wr(pcs_pkg::OFS_PWM, 8'h04);
		idle(2);
		rd(pcs_pkg::OFS_LOWDRV, 8'hF3);
		`CHK("pad.low", 8'hFF, pad[0].low)
		`CHK("pad.low", 8'hFC, pad[pcs_pkg::P_E].low)
		`CHK("pad.low", 8'h0F, pad[pcs_pkg::P_P].low)
		`CHK("low_drive_port_h", 1'b1, low_drive_port_h)
		`CHK("pull_en_port_j", 1'b1, pull_en_port_j)
		`CHK("pull_en_port_h", 1'b1, pull_en_port_h)
		`CHK("low_drive_port_j", 1'b1, low_drive_port_j)
		rd(pcs_pkg::OFS_AN0, analog_in_zero_pins);
		rd(pcs_pkg::OFS_AN1, analog_in_one_pins);
		`CHK("can_rx_pull", 3'h7, can_rx_pull)
		idle(2);
		$display("test drive done");
		finish_test();
	end
endmodule : tb
`default_nettype wire
